// *** design/pdt_pkg.sv ***
// Package: register map, field positions and encodings for the dual timer
package pdt_pkg;
   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h01;
   localparam logic [7:0] ADDR_TA_MODE = 8'h08;
   localparam logic [7:0] ADDR_TB_MODE = 8'h09;
   localparam logic [7:0] ADDR_TB_LOW = 8'h0a;
   localparam logic [7:0] ADDR_TB_HIGH = 8'h0b;
   localparam logic [7:0] ADDR_CTRL = 8'h0d;
   // -------------------------------------------------------------
   // Fields and reset values
   // -------------------------------------------------------------
   localparam int FLAG_TA_BIT = 0;
   localparam int FLAG_TB_BIT = 2;
   localparam int TA_CLR_BIT = 3;
   localparam int RELOAD_EN_BIT = 3;
   localparam int CTRL_STOP_BIT = 0;
   localparam logic [3:0] MODE_RESET = 4'h0;
   localparam logic [7:0] LOAD_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam int PRE_WIDTH = 11;
   localparam logic [2:0] TB_SRC_EXT = 3'h7;
   localparam int TB_MODE_DELAY = 2;
   localparam logic [10:0] PRE_RESET = 11'h000;

   typedef struct packed {
      logic [7:0] addr;
      logic [3:0] wdata;
      logic wr;
      logic rd;
   } pdt_bus_t;

   typedef enum logic [1:0] {
      TBM_IDLE = 2'b01,
      TBM_WAIT = 2'b10
   } pdt_tbm_t;

   typedef struct packed {
      logic [10:0] pre;
      logic [7:0] cntA;
      logic [7:0] cntB;
      logic [3:0] modeA;
      logic [3:0] modeB;
      logic [3:0] modeBPend;
      logic [1:0] modeBDly;
      pdt_tbm_t tbm;
      logic [7:0] load;
      logic [3:0] latchLow;
      logic [3:0] rdata;
      logic flagA;
      logic flagB;
      logic stop;
      logic wdReset;
      logic [10:0] preDly;
      logic [1:0] extSync;
      logic extPrev;
   } pdt_state_t;
endpackage : pdt_pkg

// *** design/pdt_timer.sv ***
// Prescaler with free-running/watchdog timer A and reload timer B
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
module pdt_timer
   import pdt_pkg::*;
#(
   parameter bit WATCHDOG = 1'b0,
   parameter bit EXT_RISING = 1'b0
)
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] regAddr,
   input wire logic [3:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [3:0] regRdata,
   input wire logic extEvent,
   output logic [PRE_WIDTH-1:0] preTaps,
   output logic watchdogReset,
   output logic firstTimerIrqFlag,
   output logic secondTimerIrqFlag
);
   pdt_state_t s_r;
   pdt_state_t s_nxt;
   logic [3:0] modeBEff;
   logic tickA;
   logic tickB;
   logic extEdge;
   logic [PRE_WIDTH-1:0] taps;
   pdt_bus_t bus;
   logic wdFire;
   logic wrTaMode;
   logic wrTbMode;
   logic wrTbLow;
   logic wrTbHigh;
   logic wrFlags;
   logic wrCtrl;
   logic rdTbHigh;
   logic rdTbLow;
   logic rdFlags;

   // -------------------------------------------------------------
   // Constants
   // -------------------------------------------------------------
   localparam logic [1:0] MODE_DLY_INIT = 2'(TB_MODE_DELAY - 2);
   localparam pdt_state_t ST_RESET = '{
      pre: PRE_RESET,
      cntA: 8'h00,
      cntB: 8'h00,
      modeA: MODE_RESET,
      modeB: MODE_RESET,
      modeBPend: MODE_RESET,
      modeBDly: 2'h0,
      tbm: TBM_IDLE,
      load: LOAD_RESET,
      latchLow: 4'h0,
      rdata: 4'h0,
      flagA: 1'b0,
      flagB: 1'b0,
      stop: 1'b0,
      wdReset: 1'b0,
      preDly: PRE_RESET,
      extSync: {2{~EXT_RISING}},
      extPrev: ~EXT_RISING
   };

   // -------------------------------------------------------------
   // Prescaler taps: rising edge of bit k is a /2^(k+1) tick
   // -------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PRE_WIDTH; g++)
      begin : gTap
         assign taps[g] = s_r.pre[g] & ~s_r.preDly[g];
      end
   endgenerate

   // -------------------------------------------------------------
   // Register bus carrier and address decode
   // -------------------------------------------------------------
   assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

   assign wrTaMode = bus.wr && (bus.addr == ADDR_TA_MODE);
   assign wrTbMode = bus.wr && (bus.addr == ADDR_TB_MODE);
   assign wrTbLow = bus.wr && (bus.addr == ADDR_TB_LOW);
   assign wrTbHigh = bus.wr && (bus.addr == ADDR_TB_HIGH);
   assign wrFlags = bus.wr && (bus.addr == ADDR_IRQ_FLAGS);
   assign wrCtrl = bus.wr && (bus.addr == ADDR_CTRL);
   assign rdTbHigh = bus.rd && (bus.addr == ADDR_TB_HIGH);
   assign rdTbLow = bus.rd && (bus.addr == ADDR_TB_LOW);
   assign rdFlags = bus.rd && (bus.addr == ADDR_IRQ_FLAGS);

   // -------------------------------------------------------------
   // Timer B mode in force
   // -------------------------------------------------------------
   assign modeBEff = s_r.modeB;

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      wdFire = 1'b0;
      extEdge = EXT_RISING ? (s_r.extSync[1] & ~s_r.extPrev)
                           : (~s_r.extSync[1] & s_r.extPrev);
      // Timer A tap choice
      if (WATCHDOG)
      begin
         tickA = taps[10];
      end
      else
      begin
         case (s_r.modeA[2:0])
            3'h0: tickA = taps[10];
            3'h1: tickA = taps[9];
            3'h2: tickA = taps[8];
            3'h3: tickA = taps[6];
            3'h4: tickA = taps[4];
            3'h5: tickA = taps[2];
            3'h6: tickA = taps[1];
            default: tickA = taps[0];
         endcase
      end
      // Timer B clock choice
      case (modeBEff[2:0])
         3'h0: tickB = taps[10];
         3'h1: tickB = taps[8];
         3'h2: tickB = taps[6];
         3'h3: tickB = taps[4];
         3'h4: tickB = taps[2];
         3'h5: tickB = taps[1];
         3'h6: tickB = taps[0];
         default: tickB = extEdge;
      endcase
      if (s_r.stop)
      begin
         tickA = 1'b0;
         tickB = 1'b0;
      end

      // Prescaler
      s_nxt.preDly = s_r.pre;
      if (!s_r.stop)
      begin
         s_nxt.pre = s_r.pre + 11'h001;
      end

      // Event pin synchroniser and edge memory
      s_nxt.extSync = {s_r.extSync[0], extEvent};
      s_nxt.extPrev = s_r.extSync[1];

      // Single-cycle outputs
      s_nxt.wdReset = 1'b0;
      s_nxt.rdata = 4'h0;

      // Flag write first, so a flag set below wins
      if (wrFlags)
      begin
         s_nxt.flagA = bus.wdata[FLAG_TA_BIT];
         s_nxt.flagB = bus.wdata[FLAG_TB_BIT];
      end

      // Timer A count and overflow
      if (tickA)
      begin
         if (s_r.cntA == COUNT_MAX)
         begin
            s_nxt.cntA = 8'h00;
            if (WATCHDOG)
            begin
               wdFire = 1'b1;
            end
            else
            begin
               s_nxt.flagA = 1'b1;
            end
         end
         else
         begin
            s_nxt.cntA = s_r.cntA + 8'h01;
         end
      end

      // Timer A mode write and watchdog clear
      if (wrTaMode)
      begin
         s_nxt.modeA = bus.wdata;
         if (WATCHDOG && bus.wdata[TA_CLR_BIT])
         begin
            s_nxt.cntA = 8'h00;
         end
      end

      // Timer B count, overflow and reload
      if (tickB)
      begin
         if (s_r.cntB == COUNT_MAX)
         begin
            s_nxt.flagB = 1'b1;
            if (modeBEff[RELOAD_EN_BIT])
            begin
               s_nxt.cntB = s_r.load;
            end
            else
            begin
               s_nxt.cntB = 8'h00;
            end
         end
         else
         begin
            s_nxt.cntB = s_r.cntB + 8'h01;
         end
      end

      // Timer B mode: new value in force from the second cycle
      case (s_r.tbm)
         TBM_IDLE:
         begin
            s_nxt.tbm = TBM_IDLE;
         end
         TBM_WAIT:
         begin
            if (s_r.modeBDly == 2'h0)
            begin
               s_nxt.modeB = s_r.modeBPend;
               s_nxt.tbm = TBM_IDLE;
            end
            else
            begin
               s_nxt.modeBDly = s_r.modeBDly - 2'h1;
            end
         end
         default:
         begin
            s_nxt.tbm = TBM_IDLE;
         end
      endcase
      if (wrTbMode)
      begin
         s_nxt.modeBPend = bus.wdata;
         s_nxt.modeBDly = MODE_DLY_INIT;
         s_nxt.tbm = TBM_WAIT;
      end

      // Load register; high digit presets the counter
      if (wrTbLow)
      begin
         s_nxt.load[3:0] = bus.wdata;
      end
      if (wrTbHigh)
      begin
         s_nxt.load[7:4] = bus.wdata;
         s_nxt.cntB = {bus.wdata, s_r.load[3:0]};
      end

      // Stop control
      if (wrCtrl)
      begin
         s_nxt.stop = bus.wdata[CTRL_STOP_BIT];
      end

      // Read data, valid in the cycle after the strobe
      if (rdTbHigh)
      begin
         s_nxt.rdata = s_r.cntB[7:4];
         s_nxt.latchLow = s_r.cntB[3:0];
      end
      else if (rdTbLow)
      begin
         s_nxt.rdata = s_r.latchLow;
      end
      else if (rdFlags)
      begin
         s_nxt.rdata[FLAG_TA_BIT] = s_r.flagA;
         s_nxt.rdata[FLAG_TB_BIT] = s_r.flagB;
      end

      // Watchdog overflow resets the whole block
      if (wdFire)
      begin
         s_nxt = ST_RESET;
         s_nxt.wdReset = 1'b1;
      end
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         s_r <= ST_RESET;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign regRdata = s_r.rdata;
   assign preTaps = s_r.pre;
   assign watchdogReset = s_r.wdReset;
   assign firstTimerIrqFlag = s_r.flagA;
   assign secondTimerIrqFlag = s_r.flagB;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cbDef @(posedge core_clk);
   endclocking
   default disable iff (srst);

   sequence tbWrapSeq;
      tickB && (s_r.cntB == COUNT_MAX) && !wrTbHigh && !wdFire;
   endsequence

   sequence modeWrIdleSeq;
      wrTbMode && (s_r.tbm == TBM_IDLE) && !wdFire;
   endsequence

   sequence modeWrSeq;
      wrTbMode && !wdFire;
   endsequence

   sequence noModeWrSeq;
      !wrTbMode && !wdFire;
   endsequence

   chk_pre_count: assert property (
      !s_r.stop && !wdFire |=> s_r.pre == $past(s_r.pre) + 11'h001)
      else $error("prescaler did not advance");

   chk_stop_hold: assert property (
      s_r.stop && !wdFire |=> s_r.pre == $past(s_r.pre))
      else $error("prescaler moved while stopped");

   chk_ta_wrap: assert property (
      tickA && (s_r.cntA == COUNT_MAX) && !WATCHDOG
      |=> s_r.flagA && (s_r.cntA == 8'h00))
      else $error("timer A overflow not flagged");

   chk_tb_wrap: assert property (
      tbWrapSeq |=> s_r.flagB && (s_r.cntB ==
         ($past(modeBEff[RELOAD_EN_BIT]) ? $past(s_r.load) : 8'h00)))
      else $error("timer B overflow wrong");

   chk_tb_preset: assert property (
      wrTbHigh && !wdFire
      |=> s_r.cntB == {$past(bus.wdata), $past(s_r.load[3:0])})
      else $error("timer B preset wrong");

   chk_mode_hold: assert property (
      modeWrIdleSeq |=> s_r.modeB == $past(s_r.modeB))
      else $error("timer B mode changed too early");

   chk_mode_apply: assert property (
      modeWrSeq ##1 noModeWrSeq |=> s_r.modeB == $past(bus.wdata, 2))
      else $error("timer B mode not applied");

   chk_rd_latch: assert property (
      rdTbHigh && !wdFire
      |=> (s_r.rdata == $past(s_r.cntB[7:4]))
          && (s_r.latchLow == $past(s_r.cntB[3:0])))
      else $error("count high read or low latch wrong");
endmodule : pdt_timer

// *** sim/prescaled_dual_timer_tb_top.sv ***
// Testbench for the prescaled dual timer
`timescale 1ns/10ps
module prescaled_dual_timer_tb_top;
   import pdt_pkg::*;
   logic core_clk = 0, srst = 1, regWr = 0, regRd = 0, extEvent = 1;
   logic [7:0] regAddr = 8'h00;
   logic [3:0] regWdata = 4'h0, regRdata, d;
   logic [10:0] preTaps, p0;
   logic wdRst, fa, fb;
   int error_cnt = 0, cmp_count = 0, n;
   pdt_timer pdt_timer_inst (.core_clk(core_clk), .srst(srst),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .extEvent(extEvent),
      .preTaps(preTaps), .watchdogReset(wdRst), // no kick needed
      .firstTimerIrqFlag(fa), .secondTimerIrqFlag(fb));
   initial forever #20 core_clk = ~core_clk;
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic idle(input int c);
      regWr <= 1'b0;
      regRd <= 1'b0;
      repeat (c) @(posedge core_clk);
   endtask : idle
   task automatic wr(input logic [7:0] a, input logic [3:0] v);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      regRd <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      regAddr <= a;
      regRd <= 1'b1;
      regWr <= 1'b0;
      @(posedge core_clk);
      regRd <= 1'b0;
      @(posedge core_clk);
      d = regRdata;
   endtask : rd
   task automatic ev(input int c);
      repeat (c)
      begin
         extEvent <= 1'b0; // pin idles high, mask is CPU side
         idle(3);
         extEvent <= 1'b1;
         idle(3);
      end
   endtask : ev
   task automatic finish_test;
      $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test
   initial
   begin
      #200000 error_cnt++;
      finish_test();
   end
   initial
   begin
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      idle(2);
      chk({fa, fb, wdRst}, 3'h0);
      p0 = preTaps;
      idle(5);
      chk(preTaps, p0 + 11'h005);
      wr(ADDR_CTRL, 4'h1);
      idle(2);
      p0 = preTaps;
      idle(10);
      chk(preTaps, p0);
      wr(ADDR_CTRL, 4'h0);
      $display("Test prescaler done");
      wr(ADDR_TA_MODE, 4'h7);
      for (n = 0; n < 700 && fa !== 1'b1; n++) idle(1);
      chk(n > 400 && n < 600, 1'b1);
      $display("Test timer A done");
      wr(ADDR_TB_MODE, 4'he);
      idle(3);
      wr(ADDR_TB_LOW, 4'hd);
      wr(ADDR_TB_HIGH, 4'hf);
      rd(ADDR_TB_HIGH);
      chk(d, 4'hf);
      for (n = 0; n < 20 && fb !== 1'b1; n++) idle(1);
      chk(n < 20, 1'b1);
      rd(ADDR_TB_HIGH);
      chk(d, 4'hf);
      $display("Test timer B done");
      wr(ADDR_TB_MODE, 4'h7);
      idle(3);
      wr(ADDR_TB_LOW, 4'h0);
      wr(ADDR_TB_HIGH, 4'h0);
      ev(5);
      rd(ADDR_TB_HIGH);
      chk(d, 4'h0);
      ev(2);
      rd(ADDR_TB_LOW);
      chk(d, 4'h5);
      rd(ADDR_IRQ_FLAGS);
      chk(d, 4'h5);
      $display("Test events done");
      finish_test();
   end
endmodule : prescaled_dual_timer_tb_top
